// ### lcime_top.sv
// Purpose : Interrupt mask and edge qualification for one line channel
// Assumes : Status and event inputs come from logic on hclk
// Notes   : AHB-Lite slave, zero wait states, always OKAY
//
// Behaviour
// - Mask A bit 7 gates equalizer range interrupt; 0 enables; resets 1.
// - Mask A bit 6 gates loop activate code interrupt; resets 1.
// - Mask A bit 5 gates loop deactivate code interrupt; resets 1.
// - Mask A bit 4 gates pattern sync interrupt; resets 1.
// - Mask A bit 3 gates transmit clock loss interrupt; resets 1.
// - Mask A bit 2 gates driver failure interrupt; resets 1.
// - Mask A bit 1 gates alarm indication interrupt; resets 1.
// - Mask A bit 0 gates signal loss interrupt; resets 1.
// - Mask B bit 7 gates shaper overflow interrupt; resets 1.
// - Mask B bits 6,5 gate jitter buffer over/underflow; reset 1.
// - Mask B bit 4 gates pattern error interrupt; resets 1.
// - Mask B bit 3 gates excess zeros interrupt; resets 1.
// - Mask B bit 2 gates code violation interrupt; resets 1.
// - Mask B bit 1 gates one-second tick interrupt; resets 1.
// - Mask B bit 0 gates counter overflow interrupt; resets 1.
// - Edge bit 7: equalizer status rising only at 0, both edges at 1.
// - Edge bit 6 picks rising or both edges for loop activate.
// - Edge bit 5 picks rising or both edges for loop deactivate.
// - Edge bit 4 picks rising or both edges for pattern sync.
// - Edge bit 3 picks rising or both edges for clock loss.
// - Edge bit 2 picks rising or both edges for driver fault.
// - Edge bits 1,0 pick edges for alarm and signal loss; reset 0.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "lcime_consts.svh"

module lcime_top
  import lcime_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Real-time status bits
  input  wire logic        equalizer_range_state,
  input  wire logic        loop_activate_state,
  input  wire logic        loop_deactivate_state,
  input  wire logic        pattern_sync_state,
  input  wire logic        tx_clock_loss_state,
  input  wire logic        driver_fault_state,
  input  wire logic        alarm_indication_state,
  input  wire logic        signal_loss_state,
  // One-cycle event pulses
  input  wire logic        shaper_overflow_evt,
  input  wire logic        jitter_buf_over_evt,
  input  wire logic        jitter_buf_under_evt,
  input  wire logic        pattern_error_evt,
  input  wire logic        excess_zero_evt,
  input  wire logic        code_violation_evt,
  input  wire logic        second_tick_evt,
  input  wire logic        counter_overflow_evt,
  // Interrupt request
  output logic             irq
);

  // ****************************************************
  // Declarations
  // ****************************************************
  lcime_state_t state_ff;
  lcime_state_t nxt_state;
  logic [7:0]   line_status_register;
  logic [7:0]   pulse_evt;
  logic [7:0]   rise;
  logic [7:0]   fall;
  logic [7:0]   stat_evt;
  logic         addr_ok;
  logic [7:0]   addr_idx;

  // Gather the status bits in register bit order
  assign line_status_register = {equalizer_range_state, loop_activate_state,
                                 loop_deactivate_state, pattern_sync_state,
                                 tx_clock_loss_state, driver_fault_state,
                                 alarm_indication_state, signal_loss_state};

  // Pulse sources in mask B bit order
  assign pulse_evt = {shaper_overflow_evt, jitter_buf_over_evt,
                      jitter_buf_under_evt, pattern_error_evt,
                      excess_zero_evt, code_violation_evt,
                      second_tick_evt, counter_overflow_evt};

  // ****************************************************
  // Edge qualification, one slice per status bit
  // ****************************************************
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_edge
      // Last-cycle copy means a held level gives no repeat event
      assign rise[g]     = line_status_register[g] & ~state_ff.prev[g];
      assign fall[g]     = ~line_status_register[g] & state_ff.prev[g];
      // Falling edge counts only when both edges are selected
      assign stat_evt[g] = rise[g] | (state_ff.edge_sel[g] & fall[g]);
    end
  endgenerate

  // Address phase decode; low bits and upper address ignored
  assign addr_ok  = hsel & hready & htrans[`LCIME_TRANS_BIT];
  assign addr_idx = haddr[9:2];

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.ready = 1'b1;
    nxt_state.resp  = `LCIME_RESP_OKAY;
    nxt_state.seen  = 1'b1;
    nxt_state.prev  = line_status_register;
    // Write data phase; unmapped indices are ignored
    if (state_ff.dp_wr)
    begin
      case (state_ff.dp_idx)
        `LCIME_IDX_MASK_A: nxt_state.mask_a = hwdata[7:0];
        `LCIME_IDX_MASK_B: nxt_state.mask_b = hwdata[7:0];
        `LCIME_IDX_EDGE:   nxt_state.edge_sel = hwdata[7:0];
        `LCIME_IDX_PEND:   nxt_state.pend = state_ff.pend & ~hwdata[15:0];
        default:           nxt_state.mask_a = state_ff.mask_a;
      endcase
    end
    // Set after clear so an event in the clearing cycle survives
    nxt_state.pend = nxt_state.pend | {stat_evt, pulse_evt};
    // Request from registered flags keeps the output glitch free
    nxt_state.irq = |(state_ff.pend & ~{state_ff.mask_a, state_ff.mask_b});
    // Capture a new address phase
    nxt_state.dp_wr  = addr_ok & hwrite;
    nxt_state.dp_idx = addr_idx;
    // Read data uses post-write values, so read-after-write is coherent
    if (addr_ok && !hwrite)
    begin
      case (addr_idx)
        `LCIME_IDX_MASK_A: nxt_state.rdata = {24'h000000, nxt_state.mask_a};
        `LCIME_IDX_MASK_B: nxt_state.rdata = {24'h000000, nxt_state.mask_b};
        `LCIME_IDX_EDGE:   nxt_state.rdata = {24'h000000, nxt_state.edge_sel};
        `LCIME_IDX_STATUS: nxt_state.rdata = {24'h000000, state_ff.prev};
        `LCIME_IDX_PEND:   nxt_state.rdata = {16'h0000, nxt_state.pend};
        default:           nxt_state.rdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff          <= '0;
      state_ff.mask_a   <= `LCIME_RST_MASK;
      state_ff.mask_b   <= `LCIME_RST_MASK;
      state_ff.edge_sel <= `LCIME_RST_EDGE;
      state_ff.pend     <= `LCIME_RST_PEND;
      state_ff.ready    <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state flops
  assign hreadyout = state_ff.ready;
  assign hresp     = state_ff.resp;
  assign hrdata    = state_ff.rdata;
  assign irq       = state_ff.irq;

  // ****************************************************
  // Checks
  // ****************************************************
  AST_RESET_VALUES: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.seen |-> (state_ff.mask_a == 8'hFF && state_ff.mask_b == 8'hFF
                        && state_ff.edge_sel == 8'h00))
    else $error("register reset values wrong");

  AST_IRQ_ON: assert property (@(posedge hclk) disable iff (!hresetn)
    |(state_ff.pend & ~{state_ff.mask_a, state_ff.mask_b}) |=> irq)
    else $error("unmasked pending flag gave no request");

  AST_IRQ_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_ff.pend & ~{state_ff.mask_a, state_ff.mask_b}) == 16'h0000 |=> !irq)
    else $error("request without unmasked pending flag");

  AST_RISE_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    (line_status_register & ~state_ff.prev) != 8'h00 |=>
      (state_ff.pend[15:8] & $past(rise)) == $past(rise))
    else $error("rising status edge lost");

  AST_FALL_IGNORED: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall & ~state_ff.edge_sel & ~state_ff.pend[15:8]) != 8'h00 && !state_ff.dp_wr |=>
      (state_ff.pend[15:8] & $past(fall & ~state_ff.edge_sel & ~state_ff.pend[15:8])) == 8'h00)
    else $error("falling edge counted in rising-only mode");

  AST_FALL_BOTH: assert property (@(posedge hclk) disable iff (!hresetn)
    (fall & state_ff.edge_sel) != 8'h00 |=>
      (state_ff.pend[15:8] & $past(fall & state_ff.edge_sel)) == $past(fall & state_ff.edge_sel))
    else $error("falling edge lost in both-edge mode");

  AST_PULSE_SETS: assert property (@(posedge hclk) disable iff (!hresetn)
    pulse_evt != 8'h00 |=> (state_ff.pend[7:0] & $past(pulse_evt)) == $past(pulse_evt))
    else $error("event pulse lost");

  AST_MASK_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
    !(state_ff.dp_wr && state_ff.dp_idx == 8'h11) |=> $stable(state_ff.mask_a))
    else $error("mask changed without a write");

  AST_READ_MASK_B: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && addr_idx == 8'h12 |=> hrdata == {24'h000000, state_ff.mask_b})
    else $error("mask B readback wrong");

  AST_ALWAYS_READY: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.seen |-> hreadyout && !hresp)
    else $error("slave stalled or erred");

  // ****************************************************
  // Per-source gating: a lone pending flag follows its mask
  // ****************************************************
  // One flag at a time, so each mask bit is seen on its own
  AST_GATE_A7: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h8000 |=> irq == !$past(state_ff.mask_a[7]))
    else $error("equalizer range gating wrong");

  AST_GATE_A6: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h4000 |=> irq == !$past(state_ff.mask_a[6]))
    else $error("loop activate gating wrong");

  AST_GATE_A5: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h2000 |=> irq == !$past(state_ff.mask_a[5]))
    else $error("loop deactivate gating wrong");

  AST_GATE_A4: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h1000 |=> irq == !$past(state_ff.mask_a[4]))
    else $error("pattern sync gating wrong");

  AST_GATE_A3: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0800 |=> irq == !$past(state_ff.mask_a[3]))
    else $error("clock loss gating wrong");

  AST_GATE_A2: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0400 |=> irq == !$past(state_ff.mask_a[2]))
    else $error("driver fault gating wrong");

  AST_GATE_A1: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0200 |=> irq == !$past(state_ff.mask_a[1]))
    else $error("alarm indication gating wrong");

  AST_GATE_A0: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0100 |=> irq == !$past(state_ff.mask_a[0]))
    else $error("signal loss gating wrong");

  AST_GATE_B7: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0080 |=> irq == !$past(state_ff.mask_b[7]))
    else $error("shaper overflow gating wrong");

  AST_GATE_B6: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0040 |=> irq == !$past(state_ff.mask_b[6]))
    else $error("jitter overflow gating wrong");

  AST_GATE_B5: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0020 |=> irq == !$past(state_ff.mask_b[5]))
    else $error("jitter underflow gating wrong");

  AST_GATE_B4: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0010 |=> irq == !$past(state_ff.mask_b[4]))
    else $error("pattern error gating wrong");

  AST_GATE_B3: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0008 |=> irq == !$past(state_ff.mask_b[3]))
    else $error("excess zero gating wrong");

  AST_GATE_B2: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0004 |=> irq == !$past(state_ff.mask_b[2]))
    else $error("code violation gating wrong");

  AST_GATE_B1: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0002 |=> irq == !$past(state_ff.mask_b[1]))
    else $error("second tick gating wrong");

  AST_GATE_B0: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.pend == 16'h0001 |=> irq == !$past(state_ff.mask_b[0]))
    else $error("counter overflow gating wrong");

  // ****************************************************
  // Per-source edge choice: rising-only drops a fall
  // ****************************************************
  // Only a clear flag can show that a fall set nothing
  AST_EDGE_B7: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[15] && fall[7] && !state_ff.edge_sel[7] |=> !state_ff.pend[15])
    else $error("equalizer fall counted");

  AST_EDGE_B6: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[14] && fall[6] && !state_ff.edge_sel[6] |=> !state_ff.pend[14])
    else $error("loop activate fall counted");

  AST_EDGE_B5: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[13] && fall[5] && !state_ff.edge_sel[5] |=> !state_ff.pend[13])
    else $error("loop deactivate fall counted");

  AST_EDGE_B4: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[12] && fall[4] && !state_ff.edge_sel[4] |=> !state_ff.pend[12])
    else $error("pattern sync fall counted");

  AST_EDGE_B3: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[11] && fall[3] && !state_ff.edge_sel[3] |=> !state_ff.pend[11])
    else $error("clock loss fall counted");

  AST_EDGE_B2: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[10] && fall[2] && !state_ff.edge_sel[2] |=> !state_ff.pend[10])
    else $error("driver fault fall counted");

  AST_EDGE_B1: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[9] && fall[1] && !state_ff.edge_sel[1] |=> !state_ff.pend[9])
    else $error("alarm indication fall counted");

  AST_EDGE_B0: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.pend[8] && fall[0] && !state_ff.edge_sel[0] |=> !state_ff.pend[8])
    else $error("signal loss fall counted");

  // ****************************************************
  // Register upkeep
  // ****************************************************
  // Write-one-to-clear drops only the bits written
  AST_PEND_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
    state_ff.dp_wr && state_ff.dp_idx == `LCIME_IDX_PEND && {stat_evt, pulse_evt} == 16'h0000
      |=> state_ff.pend == ($past(state_ff.pend) & ~$past(hwdata[15:0])))
    else $error("pending clear wrong");

  // Flags never drop without a clear write
  AST_PEND_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
    !(state_ff.dp_wr && state_ff.dp_idx == `LCIME_IDX_PEND) |=>
      (state_ff.pend & $past(state_ff.pend)) == $past(state_ff.pend))
    else $error("pending flag lost");

  // No request straight out of reset
  AST_IRQ_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
    !state_ff.seen |-> !irq)
    else $error("request right after reset");

  // Edge choice only moves on its own write
  AST_EDGE_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
    !(state_ff.dp_wr && state_ff.dp_idx == `LCIME_IDX_EDGE) |=> $stable(state_ff.edge_sel))
    else $error("edge select changed without a write");

  // Mask B only moves on its own write
  AST_MASK_B_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
    !(state_ff.dp_wr && state_ff.dp_idx == `LCIME_IDX_MASK_B) |=> $stable(state_ff.mask_b))
    else $error("mask B changed without a write");

  // Mask A reads back in the data phase
  AST_READ_MASK_A: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite && addr_idx == `LCIME_IDX_MASK_A |=> hrdata == {24'h000000, state_ff.mask_a})
    else $error("mask A readback wrong");

endmodule : lcime_top

// ### lcime_consts.svh
// Purpose : Offsets, reset values and codes of the line interrupt block
// Assumes : Included by the top module and the testbench
// Notes   : Offsets are register indices; byte address = 4 * index
`ifndef LCIME_CONSTS_SVH
`define LCIME_CONSTS_SVH

// ****************************************************
// Register indices
// ****************************************************
`define LCIME_IDX_MASK_A  8'h11
`define LCIME_IDX_MASK_B  8'h12
`define LCIME_IDX_EDGE    8'h13
`define LCIME_IDX_STATUS  8'h14
`define LCIME_IDX_PEND    8'h15

// ****************************************************
// Reset values and bus codes
// ****************************************************
`define LCIME_RST_MASK    8'hFF
`define LCIME_RST_EDGE    8'h00
`define LCIME_RST_PEND    16'h0000
`define LCIME_TRANS_BIT   1
`define LCIME_RESP_OKAY   1'b0

`endif

// ### lcime_pkg.sv
// Purpose : Types of the line interrupt block
// Assumes : Constants come from lcime_consts.svh
// Notes   : Whole state of the top module is one packed struct
package lcime_pkg;

  // Complete register state of the block
  typedef struct packed {
    logic [7:0]  mask_a;    // Status-source masks
    logic [7:0]  mask_b;    // Pulse-source masks
    logic [7:0]  edge_sel;  // 1: both edges count
    logic [7:0]  prev;      // Status seen last cycle
    logic [15:0] pend;      // [15:8] status, [7:0] pulse
    logic        irq;
    logic        dp_wr;     // Write data phase pending
    logic [7:0]  dp_idx;    // Index of that write
    logic        ready;
    logic        resp;
    logic [31:0] rdata;
    logic        seen;      // First cycle after reset done
  } lcime_state_t;

endpackage : lcime_pkg

// ### lcime_tb.sv
// Purpose : Self-checking bench for the line interrupt block
// Assumes : Zero-wait AHB-Lite slave, status levels on hclk
// Notes   : Every source is checked unmasked; status sources walk their edge choice, pulse sources their mask
`timescale 1ns/1ps
`include "lcime_consts.svh"

module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  st, ev;
  int          mismatches, check_count;

  // Status bits 7..0 and pulse sources 7..0 as vectors
  lcime_top dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
    .equalizer_range_state(st[7]), .loop_activate_state(st[6]),
    .loop_deactivate_state(st[5]), .pattern_sync_state(st[4]),
    .tx_clock_loss_state(st[3]), .driver_fault_state(st[2]),
    .alarm_indication_state(st[1]), .signal_loss_state(st[0]),
    .shaper_overflow_evt(ev[7]), .jitter_buf_over_evt(ev[6]),
    .jitter_buf_under_evt(ev[5]), .pattern_error_evt(ev[4]),
    .excess_zero_evt(ev[3]), .code_violation_evt(ev[2]),
    .second_tick_evt(ev[1]), .counter_overflow_evt(ev[0])
  );

  // 50 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Single word transfer; the master never assumes the slave is fast
  task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // Sampled after the edge so the registered request has settled
  task irq_is(input logic exp);
    #1;
    check({31'h0, irq}, {31'h0, exp});
    @(posedge hclk);
  endtask : irq_is

  task pend_is(input logic [15:0] exp);
    bus(1'b0, `LCIME_IDX_PEND, 32'h0);
    check(rd, {16'h0, exp});
    check({31'h0, hresp}, 32'h0);
  endtask : pend_is

  // Reset in mid-run restores mask A and leaves the request low
  task mid_reset;
    bus(1'b1, `LCIME_IDX_MASK_A, 32'h0);
    hresetn <= 1'b0;
    tick(2);
    hresetn <= 1'b1;
    tick(1);
    bus(1'b0, `LCIME_IDX_MASK_A, 32'h0);
    check(rd, {24'h0, `LCIME_RST_MASK});
    check({31'h0, irq}, 32'h0);
  endtask : mid_reset

  // ********************
  // Scenarios
  // ********************
  task reset_values;
    bus(1'b0, `LCIME_IDX_MASK_A, 32'h0);
    check(rd, {24'h0, `LCIME_RST_MASK});
    bus(1'b0, `LCIME_IDX_MASK_B, 32'h0);
    check(rd, {24'h0, `LCIME_RST_MASK});
    bus(1'b0, `LCIME_IDX_EDGE, 32'h0);
    check(rd, {24'h0, `LCIME_RST_EDGE});
    bus(1'b1, 8'h30, 32'hFFFF_FFFF);
    bus(1'b0, 8'h30, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `LCIME_IDX_EDGE, 32'hA5);
    bus(1'b0, `LCIME_IDX_EDGE, 32'h0);
    check(rd, 32'hA5);
    bus(1'b1, `LCIME_IDX_EDGE, 32'h0);
    pend_is(16'h0);
  endtask : reset_values

  // Rise, held level, ignored fall, then both-edge mode
  task status_src(input int i);
    logic [7:0] b;
    b = 8'h01 << i;
    bus(1'b1, `LCIME_IDX_MASK_A, {24'h0, ~b});
    st[i] <= 1'b1;
    tick(3);
    irq_is(1'b1);
    pend_is({b, 8'h00});
    bus(1'b0, `LCIME_IDX_STATUS, 32'h0);
    check(rd, {24'h0, b});
    bus(1'b1, `LCIME_IDX_PEND, {16'h0, b, 8'h00});
    tick(1);
    irq_is(1'b0);
    pend_is(16'h0);
    st[i] <= 1'b0;
    tick(3);
    pend_is(16'h0);
    bus(1'b1, `LCIME_IDX_EDGE, {24'h0, b});
    st[i] <= 1'b1;
    tick(3);
    bus(1'b1, `LCIME_IDX_PEND, 32'hFFFF);
    st[i] <= 1'b0;
    tick(3);
    irq_is(1'b1);
    pend_is({b, 8'h00});
    bus(1'b1, `LCIME_IDX_PEND, 32'hFFFF);
    bus(1'b1, `LCIME_IDX_EDGE, 32'h0);
    bus(1'b1, `LCIME_IDX_MASK_A, 32'hFF);
  endtask : status_src

  // Unmasked pulse raises the request; masked one only sets pending
  task pulse_src(input int i);
    logic [7:0] b;
    b = 8'h01 << i;
    bus(1'b1, `LCIME_IDX_MASK_B, {24'h0, ~b});
    ev[i] <= 1'b1;
    tick(1);
    ev[i] <= 1'b0;
    tick(2);
    irq_is(1'b1);
    pend_is({8'h00, b});
    bus(1'b1, `LCIME_IDX_MASK_B, 32'hFF);
    bus(1'b1, `LCIME_IDX_PEND, 32'hFFFF);
    ev[i] <= 1'b1;
    tick(1);
    ev[i] <= 1'b0;
    tick(2);
    irq_is(1'b0);
    pend_is({8'h00, b});
    bus(1'b1, `LCIME_IDX_PEND, 32'hFFFF);
  endtask : pulse_src

  task give_verdict;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // Main sequence: reset for 8 cycles, then every source in turn
  initial
  begin
    mismatches = 0;
    check_count = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, st, ev} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    @(posedge hclk);
    reset_values();
    for (int i = 0; i < 8; i++)
      status_src(i);
    for (int i = 0; i < 8; i++)
      pulse_src(i);
    mid_reset();
    give_verdict();
  end

  // Watchdog, well beyond the expected run of a few hundred cycles
  initial
  begin
    #400000;
    mismatches++;
    give_verdict();
  end
endmodule : testbench
